// File: src/php_pkg.sv
// Shared constants and types for the host message port.
// Assumes a 100 MHz system clock on both ends.
package php_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int PHP_CLK_MHZ       = 100;
    localparam int PHP_SCL_MAX_KHZ   = 400;
    localparam int PHP_HALF_CYC      = (PHP_CLK_MHZ * 1000 + 2 * PHP_SCL_MAX_KHZ - 1)
                                       / (2 * PHP_SCL_MAX_KHZ);
    localparam int PHP_SELF_RST_US   = 100;
    localparam int PHP_OD_RST_US     = 150;
    localparam int PHP_PP_RST_US     = 300;
    localparam int PHP_SELF_RST_CYC  = PHP_SELF_RST_US * PHP_CLK_MHZ;
    localparam int PHP_OD_RST_CYC    = PHP_OD_RST_US * PHP_CLK_MHZ;
    localparam int PHP_PP_RST_CYC    = PHP_PP_RST_US * PHP_CLK_MHZ;

    // ************************************************************
    // Message format
    // ************************************************************
    localparam int       PHP_MSG_BYTES  = 15;
    localparam bit [4:0] PHP_LAST_IDX   = 5'h0E;
    localparam bit [4:0] PHP_MSG_LEN    = 5'h0F;
    localparam bit [7:0] PHP_CMD_IRQ    = 8'hE0;
    localparam bit [7:0] PHP_MASK_RST   = 8'h00;
    localparam bit [3:0] PHP_BIT_ACK    = 4'h8;

    // ************************************************************
    // Addressing
    // ************************************************************
    localparam bit [6:0] PHP_ADDR_BASE  = 7'h20;
    localparam bit [2:0] PHP_LVL_UART   = 3'h0;

    typedef logic [PHP_MSG_BYTES-1:0][7:0] php_msg_t;

endpackage

// File: src/php_if.sv
// Pins between the host controller and the port device.
// Open-drain lines resolve here from both enables, pull-up assumed.
`timescale 1ns/1ps
interface php_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic host_rst_o;
    logic host_rst_oe;
    logic dev_rst_o;
    logic dev_rst_oe;
    logic host_serial_clock_line;
    logic host_serial_data_line;
    logic host_reset_n;
    logic reply_ready_n;
    logic event_irq_n;
    logic led_chain_select_n;

    // ************************************************************
    // Wired-AND resolution
    // ************************************************************
    assign host_serial_clock_line = !((host_scl_oe && !host_scl_o) || (dev_scl_oe && !dev_scl_o));
    assign host_serial_data_line  = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
    assign host_reset_n           = !((host_rst_oe && !host_rst_o) || (dev_rst_oe && !dev_rst_o));

    modport dev (
        input  host_serial_clock_line, host_serial_data_line, host_reset_n,
        output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, dev_rst_o, dev_rst_oe,
        output reply_ready_n, event_irq_n, led_chain_select_n
    );
    modport host (
        input  host_serial_clock_line, host_serial_data_line, host_reset_n,
        input  reply_ready_n, event_irq_n, led_chain_select_n,
        output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, host_rst_o, host_rst_oe
    );
endinterface

// File: src/php_dev.sv
// Device end: I2C slave for 15-byte messages, reply-ready, event interrupt,
// self reset and LED chain select. Assumes the interface resolves the pins.
`timescale 1ns/1ps
// How it works
// - Host open-drain reset pulse at least 150 us
// - Host push-pull reset pulse at least 300 us
// - Self reset drives reset pin low ~100 us
// - Host clocks link at most 400 kHz
// - Host waits while clock line held low
// - Device holds clock low while busy
// - Every message is exactly 15 bytes
// - Level input picks address or UART mode
// - Reply-ready goes low when answer held
// - Host reads only when reply-ready low
// - Reply-ready returns high after reply read
// - Interrupt low while enabled event active
// - Host sets interrupt events by message
// - LED chain select output, active low
module php_dev
    import php_pkg::*;
#(
    parameter int SELF_RST_CYC = php_pkg::PHP_SELF_RST_CYC
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    php_if.dev                     bus,
    input  wire logic [2:0]        address_select_level,
    output logic                   uart_mode,
    input  wire logic              dev_busy,
    output php_pkg::php_msg_t      cmd_msg,
    output logic                   cmd_valid,
    input  wire logic              cmd_ready,
    input  wire php_pkg::php_msg_t reply_msg,
    input  wire logic              reply_load,
    output logic                   reply_accept,
    input  wire logic [7:0]        event_active,
    output logic [7:0]             irq_mask,
    input  wire logic              self_reset_req,
    input  wire logic              led_frame
);
    import php_pkg::*;

    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_AACK, D_RX, D_RACK, D_TX, D_TACK} php_dst_t;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic       scl_m, scl_s, scl_q;
    logic       sda_m, sda_s, sda_q;
    logic       rst_m, rst_s;
    logic [2:0] lvl_m, lvl_s;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
            {rst_m, rst_s}        <= 2'h3;
            lvl_m                 <= 3'h0;
            lvl_s                 <= 3'h0;
        end else begin
            {scl_m, scl_s, scl_q} <= {bus.host_serial_clock_line, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {bus.host_serial_data_line, sda_m, sda_s};
            {rst_m, rst_s}        <= {bus.host_reset_n, rst_m};
            lvl_m                 <= address_select_level;
            lvl_s                 <= lvl_m;
        end
    end

    // ************************************************************
    // Decode
    // ************************************************************
    wire       rst       = !resetn || !rst_s;
    wire       rise      = scl_s && !scl_q;
    wire       fall      = !scl_s && scl_q;
    wire       start_c   = scl_s && scl_q && sda_q && !sda_s;
    wire       stop_c    = scl_s && scl_q && !sda_q && sda_s;
    wire       busy      = dev_busy || cmd_valid;
    wire [6:0] my_addr   = PHP_ADDR_BASE + {4'h0, lvl_s};
    wire       i2c_on    = lvl_s != PHP_LVL_UART;
    logic      pending;
    logic [7:0] sh;
    wire       addr_hit  = i2c_on && (sh[7:1] == my_addr) && (!sh[0] || pending);

    // ************************************************************
    // Slave state machine
    // ************************************************************
    php_dst_t  st;
    logic [3:0] bitc;
    logic [4:0] idx;
    logic       rd;
    logic       sda_low;
    logic       stretch;
    wire        ack_adv  = stretch || fall;
    wire        last_in  = !rd && (idx == PHP_MSG_LEN);

    always_ff @(posedge clk) begin
        if (rst) begin
            st        <= D_IDLE;
            sh        <= 8'h00;
            bitc      <= 4'h0;
            idx       <= 5'h00;
            rd        <= 1'b0;
            sda_low   <= 1'b0;
            stretch   <= 1'b0;
            pending   <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_msg   <= '0;
            irq_mask  <= PHP_MASK_RST;
        end else begin
            if (cmd_ready) begin
                cmd_valid <= 1'b0;
            end
            if (reply_load && !pending) begin
                pending <= 1'b1;
            end
            if (start_c && i2c_on) begin
                st      <= D_ADDR;
                bitc    <= 4'h0;
                sda_low <= 1'b0;
                stretch <= 1'b0;
            end else if (stop_c) begin
                st      <= D_IDLE;
                sda_low <= 1'b0;
                stretch <= 1'b0;
            end else begin
                case (st)
                    D_IDLE: begin
                        sda_low <= 1'b0;
                    end
                    D_ADDR: begin
                        if (rise) begin
                            sh   <= {sh[6:0], sda_s};
                            bitc <= bitc + 4'h1;
                        end else if (fall && bitc == PHP_BIT_ACK) begin
                            if (addr_hit) begin
                                sda_low <= 1'b1;
                                rd      <= sh[0];
                                idx     <= 5'h00;
                                st      <= D_AACK;
                            end else begin
                                st <= D_IDLE;
                            end
                        end
                    end
                    D_AACK, D_RACK: begin
                        if (ack_adv) begin
                            sh      <= reply_msg[idx];
                            sda_low <= rd && !reply_msg[idx][7];
                            if (busy && !last_in) begin
                                stretch <= 1'b1;
                            end else begin
                                stretch <= 1'b0;
                                bitc    <= 4'h0;
                                st      <= rd ? D_TX : D_RX;
                            end
                        end
                    end
                    D_RX: begin
                        if (rise) begin
                            sh   <= {sh[6:0], sda_s};
                            bitc <= bitc + 4'h1;
                        end else if (fall && bitc == PHP_BIT_ACK) begin
                            if (idx < PHP_MSG_LEN) begin
                                cmd_msg[idx] <= sh;
                                idx          <= idx + 5'h01;
                                sda_low      <= 1'b1;
                                st           <= D_RACK;
                                if (idx == PHP_LAST_IDX) begin
                                    cmd_valid <= 1'b1;
                                    if (cmd_msg[0] == PHP_CMD_IRQ) begin
                                        irq_mask <= cmd_msg[1];
                                    end
                                end
                            end else begin
                                st <= D_IDLE;
                            end
                        end
                    end
                    D_TX: begin
                        if (rise) begin
                            bitc <= bitc + 4'h1;
                        end else if (fall) begin
                            if (bitc == PHP_BIT_ACK) begin
                                sda_low <= 1'b0;
                                st      <= D_TACK;
                            end else begin
                                sda_low <= !sh[6];
                                sh      <= {sh[6:0], 1'b0};
                            end
                        end
                    end
                    D_TACK: begin
                        if (rise) begin
                            if (idx == PHP_LAST_IDX) begin
                                pending <= 1'b0;
                                st      <= D_IDLE;
                            end else if (sda_s) begin
                                st <= D_IDLE;
                            end else begin
                                idx <= idx + 5'h01;
                                st  <= D_AACK;
                            end
                        end
                    end
                    default: st <= D_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // Self reset pulse
    // ************************************************************
    logic [$clog2(SELF_RST_CYC+1)-1:0] rst_cnt;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rst_cnt <= '0;
        end else if (self_reset_req && rst_cnt == '0) begin
            rst_cnt <= ($clog2(SELF_RST_CYC+1))'(SELF_RST_CYC);
        end else if (rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 1'b1;
        end
    end

    // ************************************************************
    // Indication outputs
    // ************************************************************
    logic irq_n, ready_n, led_n;

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_n   <= 1'b1;
            ready_n <= 1'b1;
            led_n   <= 1'b1;
        end else begin
            irq_n   <= !(|(event_active & irq_mask));
            ready_n <= !pending;
            led_n   <= !led_frame;
        end
    end

    assign bus.dev_scl_o          = 1'b0;
    assign bus.dev_scl_oe         = stretch;
    assign bus.dev_sda_o          = 1'b0;
    assign bus.dev_sda_oe         = sda_low;
    assign bus.dev_rst_o          = 1'b0;
    assign bus.dev_rst_oe         = rst_cnt != '0;
    assign bus.reply_ready_n      = ready_n;
    assign bus.event_irq_n        = irq_n;
    assign bus.led_chain_select_n = led_n;
    assign reply_accept           = !pending;
    assign uart_mode              = !i2c_on;
endmodule

// File: src/php_host.sv
// Host end: I2C master moving 15-byte messages, polls reply-ready,
// issues reset pulses. Assumes the interface resolves the pins.
`timescale 1ns/1ps
module php_host
    import php_pkg::*;
#(
    parameter bit PUSH_PULL  = 1'b0,
    parameter int OD_RST_CYC = php_pkg::PHP_OD_RST_CYC,
    parameter int PP_RST_CYC = php_pkg::PHP_PP_RST_CYC
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    php_if.host                    bus,
    input  wire logic [6:0]        dev_addr,
    input  wire logic              start_write,
    input  wire logic              start_read,
    input  wire php_pkg::php_msg_t tx_msg,
    output logic                   host_busy,
    output logic                   done,
    output logic                   nack,
    output php_pkg::php_msg_t      rx_msg,
    output logic                   reply_avail,
    output logic                   irq_active,
    input  wire logic              reset_req
);
    import php_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_STOP_A, H_STOP_B, H_STOP_C}
        php_hst_t;

    localparam int RST_CYC = PUSH_PULL ? PP_RST_CYC : OD_RST_CYC;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic scl_m, scl_s, sda_m, sda_s, rdy_m, rdy_s, irq_m, irq_s;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            {scl_m, scl_s, sda_m, sda_s} <= 4'hF;
            {rdy_m, rdy_s, irq_m, irq_s} <= 4'hF;
        end else begin
            {scl_m, scl_s} <= {bus.host_serial_clock_line, scl_m};
            {sda_m, sda_s} <= {bus.host_serial_data_line, sda_m};
            {rdy_m, rdy_s} <= {bus.reply_ready_n, rdy_m};
            {irq_m, irq_s} <= {bus.event_irq_n, irq_m};
        end
    end

    // ************************************************************
    // Master state machine
    // ************************************************************
    php_hst_t   st;
    logic [7:0] tmr;
    logic [7:0] sh;
    logic [3:0] bitn;
    logic [4:0] byten;
    logic       rw;
    logic       scl_low;
    logic       sda_low;

    wire       half_up  = tmr == 8'(PHP_HALF_CYC - 1);
    wire       last_rx  = byten == PHP_MSG_LEN;
    wire       ack_bit  = bitn == PHP_BIT_ACK;
    wire       rx_byte  = rw && byten != 5'h00;
    wire       next_out = ack_bit ? 1'b1 : sh[7];
    wire [7:0] next_tx  = rw ? 8'hFF : tx_msg[byten];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st      <= H_IDLE;
            tmr     <= 8'h00;
            sh      <= 8'hFF;
            bitn    <= 4'h0;
            byten   <= 5'h00;
            rw      <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            done    <= 1'b0;
            nack    <= 1'b0;
            rx_msg  <= '0;
        end else begin
            done <= 1'b0;
            tmr  <= half_up ? 8'h00 : tmr + 8'h01;
            case (st)
                H_IDLE: begin
                    tmr <= 8'h00;
                    if (start_write || (start_read && !rdy_s)) begin
                        rw      <= !start_write;
                        sh      <= {dev_addr, !start_write};
                        byten   <= 5'h00;
                        bitn    <= 4'h0;
                        nack    <= 1'b0;
                        sda_low <= 1'b1;
                        st      <= H_START;
                    end
                end
                H_START: begin
                    if (half_up) begin
                        scl_low <= 1'b1;
                        sda_low <= !sh[7];
                        st      <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_up) begin
                        scl_low <= 1'b0;
                        st      <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (!scl_s) begin
                        tmr <= 8'h00;
                    end else if (half_up) begin
                        scl_low <= 1'b1;
                        st      <= H_LOW;
                        if (!ack_bit) begin
                            sh      <= {sh[6:0], sda_s};
                            bitn    <= bitn + 4'h1;
                            sda_low <= (bitn == 4'h7) ? (rx_byte && !last_rx) : !sh[6];
                        end else if (!rx_byte && sda_s) begin
                            nack    <= 1'b1;
                            sda_low <= 1'b1;
                            st      <= H_STOP_A;
                        end else begin
                            if (rx_byte) begin
                                rx_msg[byten - 5'h01] <= sh;
                            end
                            byten <= byten + 5'h01;
                            bitn  <= 4'h0;
                            if (rw ? last_rx : byten == PHP_MSG_LEN) begin
                                sda_low <= 1'b1;
                                st      <= H_STOP_A;
                            end else begin
                                sh      <= next_tx;
                                sda_low <= !next_tx[7];
                            end
                        end
                    end
                end
                H_STOP_A: begin
                    if (half_up) begin
                        scl_low <= 1'b0;
                        st      <= H_STOP_B;
                    end
                end
                H_STOP_B: begin
                    if (!scl_s) begin
                        tmr <= 8'h00;
                    end else if (half_up) begin
                        sda_low <= 1'b0;
                        st      <= H_STOP_C;
                    end
                end
                H_STOP_C: begin
                    if (half_up) begin
                        done <= 1'b1;
                        st   <= H_IDLE;
                    end
                end
                default: st <= H_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Reset pulse
    // ************************************************************
    logic [$clog2(PP_RST_CYC+OD_RST_CYC+1)-1:0] rst_cnt;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rst_cnt <= '0;
        end else if (reset_req && rst_cnt == '0) begin
            rst_cnt <= ($clog2(PP_RST_CYC+OD_RST_CYC+1))'(RST_CYC);
        end else if (rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 1'b1;
        end
    end

    assign bus.host_scl_o  = 1'b0;
    assign bus.host_scl_oe = scl_low;
    assign bus.host_sda_o  = 1'b0;
    assign bus.host_sda_oe = sda_low;
    assign bus.host_rst_o  = 1'b0;
    assign bus.host_rst_oe = rst_cnt != '0;
    assign host_busy       = st != H_IDLE;
    assign reply_avail     = !rdy_s;
    assign irq_active      = !irq_s;
endmodule

// File: tb/php_link_monitor.sv
// Link monitor: timing checks on the pins between host and device.
// Assumes the testbench top wires the interface signals in by name.
`timescale 1ns/1ps
module php_link_monitor #(
    parameter int SELF_RST_CYC = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic dev_rst_o,
    input wire logic dev_rst_oe,
    input wire logic host_serial_clock_line,
    input wire logic host_reset_n,
    input wire logic reply_ready_n,
    input wire logic event_irq_n,
    input wire logic led_chain_select_n
);
    int rst_cnt;
    always_ff @(posedge clk) rst_cnt <= (!resetn || !dev_rst_oe) ? 0 : rst_cnt + 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rst_idle; $rose(resetn) |-> reply_ready_n && event_irq_n && led_chain_select_n; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");
    property p_rst_free; $rose(resetn) |-> !dev_sda_oe && !dev_scl_oe && !dev_rst_oe; endproperty
    a_rst_free: assert property (p_rst_free) else $error("pins driven after reset");
    property p_hrst; $fell(host_reset_n) |-> ##[2:4] reply_ready_n; endproperty
    a_hrst: assert property (p_hrst) else $error("reply ready kept over reset");
    property p_self_len; $fell(dev_rst_oe) |-> rst_cnt == SELF_RST_CYC; endproperty
    a_self_len: assert property (p_self_len) else $error("self reset length wrong");
    property p_self_pin; dev_rst_oe |-> !dev_rst_o && !host_reset_n; endproperty
    a_self_pin: assert property (p_self_pin) else $error("self reset pin not low");
    property p_stretch; dev_scl_oe |-> !host_serial_clock_line; endproperty
    a_stretch: assert property (p_stretch) else $error("clock line not held low");
    property p_sda_edge; $changed(dev_sda_oe) |-> !host_serial_clock_line || !host_reset_n; endproperty
    a_sda_edge: assert property (p_sda_edge) else $error("data changed with clock high");
    property p_rdy_fall; $fell(reply_ready_n) |-> host_reset_n; endproperty
    a_rdy_fall: assert property (p_rdy_fall) else $error("reply ready during reset");
    property p_rdy_rise; $rose(reply_ready_n) |-> host_serial_clock_line || !host_reset_n; endproperty
    a_rdy_rise: assert property (p_rdy_rise) else $error("reply ready cleared early");
endmodule

// File: tb/tb_top.sv
// Testbench: host end and device end joined by the pin interface.
// Assumes php_pkg, php_if, both ends and the link monitor are compiled.
`timescale 1ns/1ps
module tb_top;
    import php_pkg::*;
    logic clk = 1'h0, resetn = 1'h0, dev_busy = 1'h0, cmd_ready = 1'h0, reply_load = 1'h0;
    logic self_reset_req = 1'h0, led_frame = 1'h0, start_write = 1'h0, start_read = 1'h0;
    logic reset_req = 1'h0, uart_mode, cmd_valid, reply_accept, host_busy, done, nack;
    logic reply_avail, irq_active;
    logic [2:0] address_select_level = 3'h3;
    logic [6:0] dev_addr = 7'h23;
    logic [7:0] event_active = 8'h00, irq_mask;
    php_msg_t   cmd_msg, rx_msg, reply_msg = '0, tx_msg = '0;
    int         fail_count = 0, tests_run = 0;
    php_if bus();
    php_dev #(.SELF_RST_CYC(20)) u_php_dev (.*);
    php_host #(.OD_RST_CYC(30)) u_php_host (.*);
    php_link_monitor #(.SELF_RST_CYC(20)) u_php_link_monitor (.clk, .resetn,
        .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe), .dev_rst_o(bus.dev_rst_o),
        .dev_rst_oe(bus.dev_rst_oe), .host_serial_clock_line(bus.host_serial_clock_line),
        .host_reset_n(bus.host_reset_n), .reply_ready_n(bus.reply_ready_n),
        .event_irq_n(bus.event_irq_n), .led_chain_select_n(bus.led_chain_select_n));
    always #5 clk = ~clk;
    // ********************
    // Tasks
    // ********************
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input string n, input logic [119:0] e, input logic [119:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task xfer(input logic rd);
        @(posedge clk);
        start_read <= rd;
        start_write <= !rd;
        @(posedge clk);
        start_read <= 1'h0;
        start_write <= 1'h0;
        for (int i = 0; i < 60000 && done !== 1'h1; i++) @(posedge clk);
    endtask
    task test_done;
        $display("checks %0d failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        tick(95000);
        fail_count++;
        test_done;
    end
    initial begin
        tick(3);
        resetn <= 1'h1;
        led_frame <= 1'h1;
        chk("idle", 3'h7, {bus.reply_ready_n, bus.event_irq_n, bus.led_chain_select_n});
        tick(3);
        chk("led", 1'h0, bus.led_chain_select_n);
        tx_msg[0] <= 8'hE0;
        tx_msg[1] <= 8'h05;
        tx_msg[14] <= 8'hA5;
        dev_busy <= 1'h1;
        fork xfer(1'h0); begin tick(4000); dev_busy <= 1'h0; end join
        chk("nack", 1'h0, nack);
        chk("msg", tx_msg, cmd_msg);
        chk("mask", 8'h05, irq_mask);
        chk("valid", 1'h1, cmd_valid);
        chk("host idle", 1'h0, host_busy);
        cmd_ready <= 1'h1;
        event_active <= 8'h04;
        tick(1);
        cmd_ready <= 1'h0;
        tick(3);
        chk("irq", 1'h0, bus.event_irq_n);
        chk("irq seen", 1'h1, irq_active);
        event_active <= 8'h02;
        reply_msg[0] <= 8'h5A;
        reply_msg[14] <= 8'hC3;
        tick(3);
        chk("irq masked", 1'h1, bus.event_irq_n);
        reply_load <= 1'h1;
        tick(1);
        reply_load <= 1'h0;
        tick(4);
        chk("ready", 1'h0, bus.reply_ready_n);
        chk("avail", 1'h1, reply_avail);
        chk("accept", 1'h0, reply_accept);
        xfer(1'h1);
        chk("rx", reply_msg, rx_msg);
        tick(4);
        chk("ready off", 1'h1, bus.reply_ready_n);
        dev_addr <= 7'h24;
        xfer(1'h0);
        chk("bad addr", 1'h1, nack);
        address_select_level <= 3'h0;
        dev_addr <= 7'h20;
        tick(4);
        chk("uart", 1'h1, uart_mode);
        xfer(1'h0);
        chk("uart nack", 1'h1, nack);
        self_reset_req <= 1'h1;
        tick(1);
        self_reset_req <= 1'h0;
        tick(3);
        chk("self rst", 1'h0, bus.host_reset_n);
        tick(40);
        reset_req <= 1'h1;
        tick(1);
        reset_req <= 1'h0;
        tick(3);
        chk("host rst", 1'h0, bus.host_reset_n);
        tick(25);
        chk("host rst held", 1'h0, bus.host_reset_n);
        tick(15);
        chk("released", 1'h1, bus.host_reset_n);
        chk("mask rst", 8'h00, irq_mask);
        test_done;
    end
endmodule
